// ===== include/mies_pkg.sv
// Constants shared by the MAC interrupt enable and status logic.
package mies_pkg;

  // Register byte addresses on the system bus.
  localparam logic [31:0] MIES_ADDR_TX_DEMAND = 32'hfff030a0;
  localparam logic [31:0] MIES_ADDR_ENABLE    = 32'hfff030ac;
  localparam logic [31:0] MIES_ADDR_STATUS    = 32'hfff030b0;

  // Reset values.
  localparam logic [31:0] MIES_ENABLE_RESET = 32'h00000000;
  localparam logic [31:0] MIES_STATUS_RESET = 32'h00000000;

  // Implemented bits: enable holds both master enables, status holds no
  // summary bits because those are derived.
  localparam logic [31:0] MIES_ENABLE_MASK = 32'h01ff4fff;
  localparam logic [31:0] MIES_STATUS_MASK = 32'h01fe4ffe;

  // Field positions.
  localparam int MIES_RX_MASTER_BIT = 0;
  localparam int MIES_RX_LO         = 1;
  localparam int MIES_RX_HI         = 14;
  localparam int MIES_TX_MASTER_BIT = 16;
  localparam int MIES_TX_LO         = 17;
  localparam int MIES_TX_HI         = 24;
  localparam int MIES_UNDERFLOW_BIT = 17;
  localparam int MIES_DESC_BIT      = 23;
  localparam int MIES_TX_BUSERR_BIT = 24;
  localparam int MIES_CTRL_FRAME_BIT = 14;
  localparam int MIES_MAX_LEN_BIT   = 8;
  localparam int MIES_RX_GOOD_BIT   = 4;
  localparam int MIES_CRC_BIT       = 1;

  // Event vector widths and positions inside the tx event vector.
  localparam int MIES_RX_EV_W       = 14;
  localparam int MIES_TX_EV_W       = 8;
  localparam int MIES_TX_EV_DESC    = 6;

endpackage

// ===== include/mies_stat_if.sv
// Set, clear and state vectors between the bus logic and the status bits.
`timescale 1ns/1ps
interface mies_stat_if;
  logic [31:0] set_vec;
  logic [31:0] clr_vec;
  logic [31:0] stat_vec;

  modport bits (
    input  set_vec,
    input  clr_vec,
    output stat_vec
  );
  modport ctrl (
    output set_vec,
    output clr_vec,
    input  stat_vec
  );
endinterface

// ===== rtl/mies_status_bits.sv
// Sticky status bits with write-one-to-clear and set priority.
`timescale 1ns/1ps
module mies_status_bits
  import mies_pkg::*;
(
  input  wire logic  clk_i,
  input  wire logic  rst_i,
  mies_stat_if.bits  st
);

  for (genvar i = 0; i < 32; i++) begin : g_bit
    if (MIES_STATUS_MASK[i]) begin : g_impl
      logic bit_reg;
      logic bit_next;

      // A set in the same cycle as a clear wins, so no event is lost.
      always_comb begin
        bit_next = bit_reg;
        if (st.clr_vec[i]) begin
          bit_next = 1'b0;
        end
        if (st.set_vec[i]) begin
          bit_next = 1'b1;
        end
      end

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          bit_reg <= MIES_STATUS_RESET[i];
        end else begin
          bit_reg <= bit_next;
        end
      end

      assign st.stat_vec[i] = bit_reg;

      AST_SET_WINS: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (st.set_vec[i] && st.clr_vec[i]) |=> bit_reg
      ) else $error("status bit lost a set that met a clear");
    end else begin : g_rsvd
      assign st.stat_vec[i] = 1'b0;
    end
  end

endmodule // mies_status_bits

// ===== rtl/mies_top.sv
// MAC interrupt enable and status registers with a classic Wishbone slave.
`timescale 1ns/1ps
module mies_top
  import mies_pkg::*;
(
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire logic [31:0]             wb_adr_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic [31:0]             wb_dat_i,
  output      logic [31:0]             wb_dat_o,
  output      logic                    wb_ack_o,
  input  wire logic [MIES_RX_EV_W-1:0] rx_event_i,
  input  wire logic [MIES_TX_EV_W-1:0] tx_event_i,
  output      logic                    rx_irq_o,
  output      logic                    tx_irq_o,
  output      logic                    tx_dma_halted_o,
  output      logic                    tx_resume_o
);

  // Expands byte selects into a bit mask for the data word.
  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    logic [31:0] m;
    m = 32'h00000000;
    for (int b = 0; b < 4; b++) begin
      m[b*8 +: 8] = {8{sel[b]}};
    end
    return m;
  endfunction

  // Enable-gated sources within a field span.
  function automatic logic any_source(input logic [31:0] st,
                                      input logic [31:0] en,
                                      input int          lo,
                                      input int          hi);
    logic r;
    r = 1'b0;
    for (int k = 0; k < 32; k++) begin
      if (k >= lo && k <= hi) begin
        r = r | (st[k] & en[k]);
      end
    end
    return r;
  endfunction

  mies_stat_if st_if ();

  logic [31:0] enable_reg;
  logic [31:0] rd_data;
  logic        ack_reg;
  logic        halt_reg;
  logic        resume_reg;
  logic        rx_irq_reg;
  logic        tx_irq_reg;
  logic        req;
  logic        commit;
  logic        wr_enable;
  logic        wr_status;
  logic        wr_demand;
  logic        rx_summary;
  logic        tx_summary;
  logic        rx_irq_next;
  logic        tx_irq_next;
  logic [31:0] wmask;
  logic [31:0] status_view;

  mies_status_bits u_bits (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .st    (st_if.bits)
  );

  // Bus decode. The write acts on the edge that samples ack, so a master
  // holding its request sees exactly one write.
  assign req       = wb_cyc_i && wb_stb_i;
  assign commit    = req && ack_reg;
  assign wmask     = lane_mask(wb_sel_i);
  assign wr_enable = commit && wb_we_i && (wb_adr_i == MIES_ADDR_ENABLE);
  assign wr_status = commit && wb_we_i && (wb_adr_i == MIES_ADDR_STATUS);
  assign wr_demand = commit && wb_we_i && (wb_adr_i == MIES_ADDR_TX_DEMAND);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req && !ack_reg;
    end
  end
  assign wb_ack_o = ack_reg;

  // Summary bits are pure functions of state, so they can never be written.
  assign rx_summary = any_source(st_if.stat_vec, enable_reg,
                                 MIES_RX_LO, MIES_RX_HI);
  assign tx_summary = any_source(st_if.stat_vec, enable_reg,
                                 MIES_TX_LO, MIES_TX_HI);

  always_comb begin
    status_view = st_if.stat_vec;
    status_view[MIES_RX_MASTER_BIT] = rx_summary;
    status_view[MIES_TX_MASTER_BIT] = tx_summary;
  end

  // Read mux; the tx demand register and unmapped words read as zero.
  always_comb begin
    rd_data = 32'h00000000;
    if (wb_adr_i == MIES_ADDR_ENABLE) begin
      rd_data = enable_reg;
    end else if (wb_adr_i == MIES_ADDR_STATUS) begin
      rd_data = status_view;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h00000000;
    end else if (req && !ack_reg && !wb_we_i) begin
      wb_dat_o <= rd_data;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      enable_reg <= MIES_ENABLE_RESET;
    end else if (wr_enable) begin
      enable_reg <= (enable_reg & ~wmask) |
                    (wb_dat_i & wmask & MIES_ENABLE_MASK);
    end
  end

  // Hardware events: rx events fill bits 14..1, tx events bits 24..17.
  // Reserved positions are dropped by the status bit mask.
  always_comb begin
    st_if.set_vec = 32'h00000000;
    st_if.set_vec[MIES_RX_HI:MIES_RX_LO] = rx_event_i;
    st_if.set_vec[MIES_TX_HI:MIES_TX_LO] = tx_event_i;
  end

  assign st_if.clr_vec = wr_status ? (wb_dat_i & wmask & MIES_STATUS_MASK)
                                   : 32'h00000000;

  // Interrupt lines, registered so that they are glitch free at the CPU.
  assign rx_irq_next = enable_reg[MIES_RX_MASTER_BIT] && rx_summary;
  assign tx_irq_next = enable_reg[MIES_TX_MASTER_BIT] && tx_summary;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_irq_reg <= 1'b0;
      tx_irq_reg <= 1'b0;
    end else begin
      rx_irq_reg <= rx_irq_next;
      tx_irq_reg <= tx_irq_next;
    end
  end
  assign rx_irq_o = rx_irq_reg;
  assign tx_irq_o = tx_irq_reg;

  // Tx DMA halt tracking. A descriptor-unavailable event arriving with a
  // demand write keeps the engine halted, since the new descriptor was
  // evidently not yet seen.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      halt_reg   <= 1'b0;
      resume_reg <= 1'b0;
    end else begin
      resume_reg <= 1'b0;
      if (tx_event_i[MIES_TX_EV_DESC]) begin
        halt_reg <= 1'b1;
      end else if (wr_demand && halt_reg) begin
        halt_reg   <= 1'b0;
        resume_reg <= 1'b1;
      end
    end
  end
  assign tx_dma_halted_o = halt_reg;
  assign tx_resume_o     = resume_reg;

  AST_TX_IRQ_CAUSE: assert property (
    @(posedge clk_i) disable iff (rst_i)
    tx_irq_o |-> $past(enable_reg[MIES_TX_MASTER_BIT] &&
      |(st_if.stat_vec[24:17] & enable_reg[24:17]))
  ) else $error("tx interrupt without an enabled tx source");

  AST_RX_IRQ_CAUSE: assert property (
    @(posedge clk_i) disable iff (rst_i)
    rx_irq_o |-> $past(enable_reg[MIES_RX_MASTER_BIT] &&
      |(st_if.stat_vec[14:1] & enable_reg[14:1]))
  ) else $error("rx interrupt without an enabled rx source");

  AST_UNDERFLOW_LATCH: assert property (
    @(posedge clk_i) disable iff (rst_i)
    tx_event_i[0] |=> st_if.stat_vec[MIES_UNDERFLOW_BIT]
  ) else $error("underflow status did not latch");

  AST_UNDERFLOW_GATE: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (enable_reg[MIES_TX_MASTER_BIT] && enable_reg[MIES_UNDERFLOW_BIT] &&
     st_if.stat_vec[MIES_UNDERFLOW_BIT]) |=> tx_irq_o
  ) else $error("underflow status did not raise tx interrupt");

  AST_TX_DESC_GATE: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (enable_reg[MIES_TX_MASTER_BIT] && enable_reg[MIES_DESC_BIT] &&
     st_if.stat_vec[MIES_DESC_BIT]) |=> tx_irq_o
  ) else $error("descriptor status did not raise tx interrupt");

  AST_TX_MASTER_OFF: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !enable_reg[MIES_TX_MASTER_BIT] |=> !tx_irq_o
  ) else $error("tx interrupt raised with tx master enable clear");

  AST_RX_MASTER_OFF: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !enable_reg[MIES_RX_MASTER_BIT] |=> !rx_irq_o
  ) else $error("rx interrupt raised with rx master enable clear");

  AST_MASKED_SILENT: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (!tx_summary && !rx_summary) |=> (!tx_irq_o && !rx_irq_o)
  ) else $error("interrupt raised with every source masked");

  AST_CTRL_FRAME_GATE: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (enable_reg[MIES_RX_MASTER_BIT] && enable_reg[MIES_CTRL_FRAME_BIT] &&
     st_if.stat_vec[MIES_CTRL_FRAME_BIT]) |=> rx_irq_o
  ) else $error("control frame status did not raise rx interrupt");

  AST_MAX_LEN_GATE: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (enable_reg[MIES_RX_MASTER_BIT] && enable_reg[MIES_MAX_LEN_BIT] &&
     st_if.stat_vec[MIES_MAX_LEN_BIT]) |=> rx_irq_o
  ) else $error("length exceeded status did not raise rx interrupt");

  AST_RX_GOOD_GATE: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (enable_reg[MIES_RX_MASTER_BIT] && enable_reg[MIES_RX_GOOD_BIT] &&
     st_if.stat_vec[MIES_RX_GOOD_BIT]) |=> rx_irq_o
  ) else $error("rx good status did not raise rx interrupt");

  AST_CRC_GATE: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (enable_reg[MIES_RX_MASTER_BIT] && enable_reg[MIES_CRC_BIT] &&
     st_if.stat_vec[MIES_CRC_BIT]) |=> rx_irq_o
  ) else $error("crc status did not raise rx interrupt");

  AST_W1C: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (st_if.clr_vec != 32'h00000000) |=>
      ((st_if.stat_vec & $past(st_if.clr_vec & ~st_if.set_vec)) == 32'h0)
  ) else $error("written one did not clear its status bit");

  AST_W1C_KEEP: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (wr_status && (st_if.set_vec == 32'h0)) |=>
      ((st_if.stat_vec & ~$past(st_if.clr_vec)) ==
       ($past(st_if.stat_vec) & ~$past(st_if.clr_vec)))
  ) else $error("status bit written with zero changed");

  AST_TX_BUSERR: assert property (
    @(posedge clk_i) disable iff (rst_i)
    tx_event_i[7] |=> st_if.stat_vec[MIES_TX_BUSERR_BIT]
  ) else $error("tx bus error status did not set");

  AST_DESC_HALT: assert property (
    @(posedge clk_i) disable iff (rst_i)
    tx_event_i[MIES_TX_EV_DESC] |=>
      (st_if.stat_vec[MIES_DESC_BIT] && tx_dma_halted_o && !tx_resume_o)
  ) else $error("descriptor unavailable did not halt tx dma");

  AST_DEMAND_IDLE: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (wr_demand && !halt_reg) |=> !tx_resume_o
  ) else $error("start demand acted while not halted");

  AST_DEMAND_RESUME: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (wr_demand && halt_reg && !tx_event_i[MIES_TX_EV_DESC]) |=>
      (tx_resume_o && !tx_dma_halted_o) ##1 !tx_resume_o
  ) else $error("start demand did not resume halted tx dma");

  AST_SUMMARY_READ: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (req && !ack_reg && !wb_we_i && wb_adr_i == MIES_ADDR_STATUS) |=>
      (wb_dat_o[MIES_TX_MASTER_BIT] == $past(tx_summary) &&
       wb_dat_o[MIES_RX_MASTER_BIT] == $past(rx_summary))
  ) else $error("status read summary bits wrong");

  AST_ACK_ONE: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o
  ) else $error("ack held longer than one cycle");

endmodule // mies_top

// ===== tb/mies_cpu_model.sv
// Software side of the CPU: a classic Wishbone master with one bus task.
`timescale 1ns/1ps
module mies_cpu_model (
  input  wire logic        clk_i,
  output      logic        cyc_o,
  output      logic        stb_o,
  output      logic        we_o,
  output      logic [31:0] adr_o,
  output      logic [3:0]  sel_o,
  output      logic [31:0] dat_o,
  input  wire logic [31:0] dat_i,
  input  wire logic        ack_i
);
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o  = 1'b0;
    adr_o = 32'h00000000;
    sel_o = 4'h0;
    dat_o = 32'h00000000;
  end

  // The request is held until ack is seen at a rising edge, then released.
  // Idle write data is inverted so a stale value can never pass as valid.
  task automatic access(input logic w, input logic [31:0] a,
                        input logic [3:0] s, input logic [31:0] d,
                        output logic [31:0] q);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o  <= w;
    adr_o <= a;
    sel_o <= s;
    dat_o <= d;
    do @(posedge clk_i); while (ack_i !== 1'b1);
    q = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    we_o  <= 1'b0;
    dat_o <= ~d;
  endtask
endmodule // mies_cpu_model

// ===== tb/mies_top_tb.sv
// Self-checking bench for the MAC interrupt enable and status block.
`timescale 1ns/1ps
module mies_top_tb;
  import mies_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc;
  logic        stb;
  logic        we;
  logic        ack;
  logic        rx_irq;
  logic        tx_irq;
  logic        halted;
  logic        resume;
  logic [3:0]  sel;
  logic [31:0] adr;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic [31:0] q;
  logic [31:0] r;
  logic [31:0] v;
  logic [31:0] c;
  logic [31:0] en_m;
  logic [31:0] st_m;
  logic [13:0] rx_ev = 14'h0000;
  logic [7:0]  tx_ev = 8'h00;
  int          bad_count = 0;
  int          comparisons = 0;
  int          resumes = 0;

  always #25 clk_i = ~clk_i;
  always @(posedge clk_i) if (resume === 1'b1) resumes <= resumes + 1;

  mies_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .rx_event_i(rx_ev),
    .tx_event_i(tx_ev), .rx_irq_o(rx_irq), .tx_irq_o(tx_irq),
    .tx_dma_halted_o(halted), .tx_resume_o(resume));
  mies_cpu_model cpu_u (.clk_i(clk_i), .cyc_o(cyc), .stb_o(stb),
    .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat), .dat_i(rdat),
    .ack_i(ack));

  function automatic logic [31:0] ev_bits(input logic [13:0] rx,
                                          input logic [7:0] tx);
    return ({17'h00000, rx, 1'b0} | {7'h00, tx, 17'h00000})
           & MIES_STATUS_MASK;
  endfunction
  function automatic logic [31:0] rd_status(input logic [31:0] s,
                                            input logic [31:0] e);
    return {s[31:17], |(s[24:17] & e[24:17]), s[15:1],
            |(s[14:1] & e[14:1])};
  endfunction
  function automatic logic [31:0] irqs(input logic [31:0] s,
                                       input logic [31:0] e);
    return {30'h0, e[16] & |(s[24:17] & e[24:17]),
            e[0] & |(s[14:1] & e[14:1])};
  endfunction

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp,
                           input string what);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    cpu_u.access(1'b1, a, s, d, q);
  endtask
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] e,
                        input string what);
    cpu_u.access(1'b0, a, 4'hf, 32'h00000000, r);
    check_val(r, e, what);
  endtask
  // One-cycle event pulse, then two edges so the interrupt has settled.
  task automatic pulse(input logic [13:0] rx, input logic [7:0] tx);
    @(posedge clk_i);
    rx_ev <= rx;
    tx_ev <= tx;
    @(posedge clk_i);
    rx_ev <= 14'h0000;
    tx_ev <= 8'h00;
    repeat (2) @(posedge clk_i);
    st_m = st_m | ev_bits(rx, tx);
  endtask
  task automatic irq_chk();
    check_val({30'h0, tx_irq, rx_irq}, irqs(st_m, en_m), "irq");
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    stop_test();
  end

  initial begin
    void'($urandom(32'h6d2867b1));
    en_m = 32'h00000000;
    st_m = 32'h00000000;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(MIES_ADDR_ENABLE, MIES_ENABLE_RESET, "enable reset");
    rd_chk(MIES_ADDR_STATUS, MIES_STATUS_RESET, "status reset");
    rd_chk(MIES_ADDR_TX_DEMAND, 32'h00000000, "demand read");
    rd_chk(32'hfff030b4, 32'h00000000, "unmapped read");
    wr(MIES_ADDR_ENABLE, 32'hffffffff, 4'h1);
    en_m = 32'h000000ff;
    rd_chk(MIES_ADDR_ENABLE, en_m, "byte lane");
    wr(MIES_ADDR_TX_DEMAND, 32'h00000001, 4'hf);
    pulse(14'h0000, 8'h40);
    check_val({31'h0, halted}, 32'h00000001, "halt");
    wr(MIES_ADDR_TX_DEMAND, 32'h00000001, 4'hf);
    repeat (2) @(posedge clk_i);
    check_val(resumes, 32'h00000001, "resume count");
    check_val({31'h0, halted}, 32'h00000000, "resumed");
    en_m = 32'h00000011;
    wr(MIES_ADDR_ENABLE, en_m, 4'hf);
    pulse(14'h0008, 8'h00);
    irq_chk();
    // Holding the event through the clearing write checks set priority.
    rx_ev <= 14'h0008;
    wr(MIES_ADDR_STATUS, 32'h00000010, 4'hf);
    rx_ev <= 14'h0000;
    rd_chk(MIES_ADDR_STATUS, rd_status(st_m, en_m), "set wins");
    for (int i = 0; i < 40; i++) begin
      v = $urandom();
      en_m = v & MIES_ENABLE_MASK;
      wr(MIES_ADDR_ENABLE, v, 4'hf);
      pulse(14'($urandom()), 8'($urandom()));
      rd_chk(MIES_ADDR_STATUS, rd_status(st_m, en_m), "status");
      irq_chk();
      c = $urandom();
      wr(MIES_ADDR_STATUS, c, 4'hf);
      st_m = st_m & ~(c & MIES_STATUS_MASK);
      repeat (2) @(posedge clk_i);
      irq_chk();
      rd_chk(MIES_ADDR_STATUS, rd_status(st_m, en_m), "cleared");
    end
    pulse(14'h0000, 8'h80);
    rd_chk(MIES_ADDR_STATUS, rd_status(st_m, en_m), "bus error");
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    en_m = 32'h00000000;
    st_m = 32'h00000000;
    rd_chk(MIES_ADDR_ENABLE, MIES_ENABLE_RESET, "enable rereset");
    rd_chk(MIES_ADDR_STATUS, MIES_STATUS_RESET, "status rereset");
    irq_chk();
    stop_test();
  end
endmodule // mies_top_tb
